// file: rtl/hrl_pkg.sv
// Constants shared by the hex record loader
package hrl_pkg;
  localparam logic [7:0] CH_S     = 8'h53;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_NUL   = 8'h00;
  localparam logic [7:0] CH_0     = 8'h30;
  localparam logic [7:0] CH_9     = 8'h39;
  localparam logic [7:0] CH_UA    = 8'h41;
  localparam logic [7:0] CH_UF    = 8'h46;
  localparam logic [7:0] CH_LA    = 8'h61;
  localparam logic [7:0] CH_LF_HX = 8'h66;
  localparam logic [7:0] HEX_OFS  = 8'h0A;
  localparam logic [7:0] CH_TY0   = 8'h30;
  localparam logic [7:0] CH_TY1   = 8'h31;
  localparam logic [7:0] CH_TY9   = 8'h39;
  localparam logic [7:0] ADDR_PAIRS = 8'h02;
  localparam logic [7:0] CSUM_OK  = 8'hFF;
  localparam int         ADDR_W   = 16;
  localparam int         DATA_W   = 8;
  typedef enum logic [1:0] {
    HRL_REC_HDR,
    HRL_REC_DATA,
    HRL_REC_END,
    HRL_REC_SKIP
  } hrl_rec_e;
endpackage : hrl_pkg

// file: rtl/hrl_buf2.sv
// Two-entry valid/ready buffer for write requests
`timescale 1ns/1ns
module hrl_buf2 #(
  parameter int W = 24
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  logic [W-1:0] mem [2];
  logic         wr_ptr;
  logic         rd_ptr;
  logic [1:0]   count;
  wire          push = i_valid && (count != 2'h2);
  wire          pop  = (count != 2'h0) && i_ready;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= i_data;
        wr_ptr      <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  assign o_ready = (count != 2'h2);
  assign o_valid = (count != 2'h0);
  assign o_data  = mem[rd_ptr];
endmodule : hrl_buf2

// file: rtl/hrl_loader.sv
// Hex load record decoder and memory writer
`timescale 1ns/1ns
module hrl_loader #(
  parameter int AW = hrl_pkg::ADDR_W,
  parameter int DW = hrl_pkg::DATA_W
) (
  input  wire logic          i_clk,
  input  wire logic          i_srst,
  input  wire logic          i_restart,
  input  wire logic          i_char_valid,
  output logic               o_char_ready,
  input  wire logic [7:0]    i_char,
  input  wire logic          i_err_clear,
  output logic               o_wr_valid,
  input  wire logic          i_wr_ready,
  output logic [AW-1:0]      o_wr_addr,
  output logic [DW-1:0]      o_wr_data,
  output logic               o_done,
  output logic [AW-1:0]      o_entry_addr,
  output logic               o_error
);
  import hrl_pkg::*;

  typedef enum logic [2:0] {
    HRL_HUNT, HRL_TYPE, HRL_HI, HRL_LO, HRL_STOP
  } hrl_state_e;

  hrl_state_e state;
  hrl_rec_e   rec;
  logic       seen_s1;
  logic [3:0] hi_nib;
  logic [7:0] pairs_left;
  logic [7:0] byte_idx;
  logic [7:0] csum;
  logic [AW-1:0] addr;
  logic       buf_ready;
  logic       buf_valid;
  logic [AW+DW-1:0] buf_data;
  logic       pend_valid;
  logic [AW+DW-1:0] pend_data;

  // Hex digit decode, upper or lower case
  wire is_dig  = (i_char >= CH_0) && (i_char <= CH_9);
  wire is_up   = (i_char >= CH_UA) && (i_char <= CH_UF);
  wire is_lo   = (i_char >= CH_LA) && (i_char <= CH_LF_HX);
  wire is_hex  = is_dig || is_up || is_lo;
  wire [7:0] nib_full = is_dig ? (i_char - CH_0) :
                        is_up  ? (i_char - CH_UA + HEX_OFS) :
                                 (i_char - CH_LA + HEX_OFS);
  wire [3:0] nib = nib_full[3:0];
  wire [7:0] cur_byte  = {hi_nib, nib};
  wire [7:0] next_csum = csum + cur_byte;
  wire is_term = (i_char == CH_CR) || (i_char == CH_LF) ||
                 (i_char == CH_NUL);
  // Stall on any character while a write is still waiting
  wire stall  = pend_valid;
  wire take   = i_char_valid && o_char_ready;
  wire last_b = (byte_idx != 8'h00) && (pairs_left == 8'h01);
  wire in_addr = (byte_idx == 8'h01) || (byte_idx == 8'h02);
  wire is_data = (byte_idx > ADDR_PAIRS) && !last_b;
  wire do_wr = take && (state == HRL_LO) && is_hex && is_data &&
               (rec == HRL_REC_DATA);
  wire bad_digit = take && ((state == HRL_HI) || (state == HRL_LO)) &&
                   !is_hex;
  wire bad_csum = take && (state == HRL_LO) && is_hex && last_b &&
                  (next_csum != CSUM_OK);
  wire bad_len = take && (state == HRL_LO) && is_hex &&
                 (byte_idx == 8'h00) && (cur_byte <= ADDR_PAIRS);
  wire rec_end = take && (state == HRL_LO) && is_hex && last_b;
  wire [AW-1:0] data_addr = addr + AW'(byte_idx - ADDR_PAIRS - 8'h01);

  always_ff @(posedge i_clk) begin
    if (i_srst || i_restart) begin
      state      <= HRL_HUNT;
      rec        <= HRL_REC_SKIP;
      seen_s1    <= 1'b0;
      hi_nib     <= 4'h0;
      pairs_left <= 8'h00;
      byte_idx   <= 8'h00;
      csum       <= 8'h00;
      addr       <= '0;
      o_done     <= 1'b0;
      o_entry_addr <= '0;
      o_char_ready <= 1'b0;
    end else begin
      o_char_ready <= (state != HRL_STOP) && !stall &&
                      !(take && (state == HRL_LO));
      if (take) begin
        unique case (state)
          HRL_HUNT: begin
            // Leading fields and line endings are dropped here
            if (i_char == CH_S) state <= HRL_TYPE;
          end
          HRL_TYPE: begin
            state    <= HRL_HI;
            byte_idx <= 8'h00;
            csum     <= 8'h00;
            if (i_char == CH_TY1) begin
              rec <= HRL_REC_DATA;
            end else if (i_char == CH_TY9 && seen_s1) begin
              rec <= HRL_REC_END;
            end else if (i_char == CH_TY0) begin
              rec <= HRL_REC_HDR;
            end else begin
              rec   <= HRL_REC_SKIP;
              state <= HRL_HUNT;
            end
          end
          HRL_HI: begin
            hi_nib <= nib;
            state  <= is_hex ? HRL_LO : HRL_HUNT;
          end
          HRL_LO: begin
            state    <= HRL_HI;
            csum     <= next_csum;
            byte_idx <= byte_idx + 8'h01;
            if (!is_hex || bad_len) begin
              state <= HRL_HUNT;
            end else if (byte_idx == 8'h00) begin
              pairs_left <= cur_byte;
            end else begin
              pairs_left <= pairs_left - 8'h01;
              if (in_addr) addr <= {addr[AW-DW-1:0], cur_byte};
              if (last_b) begin
                state <= HRL_HUNT;
                if (!bad_csum && rec == HRL_REC_DATA) seen_s1 <= 1'b1;
                if (!bad_csum && rec == HRL_REC_END) begin
                  o_done       <= 1'b1;
                  o_entry_addr <= addr;
                  state        <= HRL_STOP;
                end
              end
            end
          end
          HRL_STOP: state <= HRL_STOP;
          default:  state <= HRL_HUNT;
        endcase
      end
      if (is_term && take && state != HRL_STOP) state <= HRL_HUNT;
    end
  end

  // Sticky error; a new fault wins over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) o_error <= 1'b0;
    else if (bad_digit || bad_csum || bad_len) o_error <= 1'b1;
    else if (i_err_clear) o_error <= 1'b0;
  end

  // Holding register in front of the buffer
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pend_valid <= 1'b0;
      pend_data  <= '0;
    end else if (do_wr) begin
      pend_valid <= 1'b1;
      pend_data  <= {data_addr, cur_byte};
    end else if (buf_ready) begin
      pend_valid <= 1'b0;
    end
  end

  hrl_buf2 #(.W(AW + DW)) u_buf (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_valid (pend_valid),
    .o_ready (buf_ready),
    .i_data  (pend_data),
    .o_valid (buf_valid),
    .i_ready (i_wr_ready && !o_wr_valid),
    .o_data  (buf_data)
  );

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_wr_valid <= 1'b0;
      o_wr_addr  <= '0;
      o_wr_data  <= '0;
    end else if (o_wr_valid) begin
      if (i_wr_ready) o_wr_valid <= 1'b0;
    end else if (buf_valid && i_wr_ready) begin
      o_wr_valid <= 1'b1;
      o_wr_addr  <= buf_data[AW+DW-1:DW];
      o_wr_data  <= buf_data[DW-1:0];
    end
  end

  property p_err_sticky;
    @(posedge i_clk) disable iff (i_srst)
      (bad_csum || bad_digit || bad_len) |=> o_error;
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("error flag not set");

  property p_done_entry;
    @(posedge i_clk) disable iff (i_srst)
      $rose(o_done) |-> (state == HRL_STOP);
  endproperty
  a_done_entry: assert property (p_done_entry)
    else $error("done without stop");

  // A write may only be launched while a data record is open
  property p_no_hdr_wr;
    @(posedge i_clk) disable iff (i_srst)
      $rose(pend_valid) |-> (rec == HRL_REC_DATA);
  endproperty
  a_no_hdr_wr: assert property (p_no_hdr_wr)
    else $error("write outside data record");

  property p_stop_ready;
    @(posedge i_clk) disable iff (i_srst)
      (state == HRL_STOP) |=> !o_char_ready;
  endproperty
  a_stop_ready: assert property (p_stop_ready)
    else $error("char taken after done");

  property p_wr_hold;
    @(posedge i_clk) disable iff (i_srst)
      (o_wr_valid && !i_wr_ready) |=>
        (o_wr_valid && $stable(o_wr_addr) && $stable(o_wr_data));
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write request changed before ready");

  // Gap after each low nibble gives the pending slot time to drain
  property p_lo_gap;
    @(posedge i_clk) disable iff (i_srst)
      (take && (state == HRL_LO)) |=> !o_char_ready;
  endproperty
  a_lo_gap: assert property (p_lo_gap)
    else $error("no stall after low nibble");

  property p_done_hold;
    @(posedge i_clk) disable iff (i_srst)
      (o_done && !i_restart) |=> (o_done && $stable(o_entry_addr));
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("entry address lost before restart");

  a_cv_done: cover property (@(posedge i_clk) $rose(o_done));
  a_cv_wr:   cover property (@(posedge i_clk) o_wr_valid && i_wr_ready);
  a_cv_err:  cover property (@(posedge i_clk) $rose(o_error));
endmodule : hrl_loader

// file: verification/hrl_host.sv
// Host model sending load record text
`timescale 1ns/1ns
module hrl_host (
  input  wire logic       i_clk,
  input  wire logic       i_ready,
  output logic            o_valid,
  output logic [7:0]      o_char
);
  import hrl_pkg::*;
  initial begin
    o_valid = 1'b0;
    o_char  = 8'hFF;
  end
  // Idle line shows the inverse, never a stale character
  task automatic send_char(input logic [7:0] c);
    @(negedge i_clk);
    o_valid = 1'b1;
    o_char  = c;
    do @(posedge i_clk); while (i_ready !== 1'b1);
    // Release on the next falling edge, never on the sampling edge
    @(negedge i_clk);
    o_valid = 1'b0;
    o_char  = ~c;
  endtask : send_char
  task automatic send_byte(input logic [7:0] b);
    send_char(hexc(b[7:4]));
    send_char(hexc(b[3:0]));
  endtask : send_byte
  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'hA) ? CH_0 + 8'(n) : CH_UA + 8'(n) - HEX_OFS;
  endfunction : hexc
  task automatic send_rec(input logic [7:0] ty, input logic [15:0] a,
                          input logic [7:0] d[$], input logic [7:0] bad);
    logic [7:0] s;
    s = 8'(d.size() + 3) + a[15:8] + a[7:0];
    foreach (d[i]) s += d[i];
    send_char(CH_S);
    send_char(ty);
    send_byte(8'(d.size() + 3));
    send_byte(a[15:8]);
    send_byte(a[7:0]);
    foreach (d[i]) send_byte(d[i]);
    send_byte(~s ^ bad);
    // Loader refuses all input once an end record is accepted
    if (ty != CH_TY9) begin
      send_char(CH_CR);
      send_char(CH_LF);
    end
  endtask : send_rec
endmodule : hrl_host

// file: verification/testbench.sv
// Self-checking bench for the hex record loader
`timescale 1ns/1ns
module testbench;
  import hrl_pkg::*;
  logic        i_clk, i_srst, i_restart, i_err_clear;
  logic        i_wr_ready = 1'b0;
  logic        cvalid, cready, wvalid, done, error;
  logic [7:0]  cdata, wdata;
  logic [15:0] waddr, entry, e;
  logic [31:0] seed = 32'hDFC6;
  int          n_fail = 0;
  int          comparisons = 0;
  logic [15:0] q_a[$];
  logic [7:0]  q_d[$], d[$];
  string       junk = "07 x";
  hrl_loader uut (.i_clk(i_clk), .i_srst(i_srst), .i_restart(i_restart),
    .i_char_valid(cvalid), .o_char_ready(cready), .i_char(cdata),
    .i_err_clear(i_err_clear), .o_wr_valid(wvalid), .i_wr_ready(i_wr_ready),
    .o_wr_addr(waddr), .o_wr_data(wdata), .o_done(done),
    .o_entry_addr(entry), .o_error(error));
  hrl_host host (.i_clk(i_clk), .i_ready(cready), .o_valid(cvalid),
    .o_char(cdata));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_flag(input logic got, input logic exp);
    cmp_val({15'h0000, got}, {15'h0000, exp});
  endtask : cmp_flag
  // Memory side stalls at random to exercise the buffer
  always @(negedge i_clk) i_wr_ready <= 1'(rnd() >> 3);
  always @(posedge i_clk) begin
    if (wvalid === 1'b1 && i_wr_ready === 1'b1) begin
      if (q_a.size() == 0) cmp_val(waddr, ~waddr);
      else begin
        cmp_val(waddr, q_a.pop_front());
        cmp_val({8'h00, wdata}, {8'h00, q_d.pop_front()});
      end
    end
  end
  task automatic load(input logic [15:0] a, input int n, input logic [7:0] b);
    d = {};
    repeat (n) begin
      d.push_back(8'(rnd()));
      q_a.push_back(a + 16'(d.size() - 1));
      q_d.push_back(d[$]);
    end
    host.send_rec(CH_TY1, a, d, b);
  endtask : load
  task automatic settle(input logic exp);
    for (int i = 0; i < 300 && (q_a.size() != 0 || done !== exp); i++)
      @(negedge i_clk);
    cmp_flag(done, exp);
  endtask : settle
  task automatic pulse(ref logic s);
    @(negedge i_clk) s = 1'b1;
    @(negedge i_clk) s = 1'b0;
  endtask : pulse
  task automatic complete_run();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  initial begin
    #2000000;
    n_fail++;
    complete_run();
  end
  initial begin
    i_srst = 1'b1;
    i_restart = 1'b0;
    i_err_clear = 1'b0;
    repeat (8) @(negedge i_clk);
    i_srst = 1'b0;
    for (int i = 0; i < junk.len(); i++) host.send_char(junk[i]);
    d = {8'h48, 8'h44, 8'h52};
    host.send_rec(CH_TY0, 16'h0000, d, 8'h00);
    d = {};
    host.send_rec(CH_TY9, 16'h1234, d, 8'h00);
    load(16'(rnd()), 0, 8'h00);
    host.send_char(CH_NUL);
    for (int i = 0; i < 4; i++) load(16'(rnd()), 1 + i * 2, 8'h00);
    e = 16'(rnd());
    d = {};
    host.send_rec(CH_TY9, e, d, 8'h00);
    settle(1'b1);
    cmp_val(entry, e);
    cmp_flag(error, 1'b0);
    repeat (4) @(negedge i_clk);
    cmp_flag(cready, 1'b0);
    $display("test good_load done");
    pulse(i_restart);
    load(16'hFFFE, 3, 8'h01);
    d = {};
    host.send_rec(CH_TY9, 16'h0000, d, 8'h00);
    settle(1'b0);
    cmp_flag(error, 1'b1);
    load(16'h0100, 2, 8'h00);
    d = {};
    host.send_rec(CH_TY9, 16'hABCD, d, 8'h00);
    settle(1'b1);
    cmp_val(entry, 16'hABCD);
    cmp_flag(error, 1'b1);
    pulse(i_err_clear);
    @(negedge i_clk);
    cmp_flag(error, 1'b0);
    $display("test bad_checksum done");
    pulse(i_restart);
    // Lower-case digits, checksum included
    q_a.push_back(16'h0200);
    q_d.push_back(8'hAB);
    junk = "S1040200ab4e";
    for (int i = 0; i < junk.len(); i++) host.send_char(junk[i]);
    settle(1'b0);
    cmp_flag(error, 1'b0);
    host.send_char(CH_S);
    host.send_char(CH_TY1);
    host.send_char(8'h47);
    host.send_char(CH_CR);
    repeat (4) @(negedge i_clk);
    cmp_flag(error, 1'b1);
    $display("test bad_digit done");
    complete_run();
  end
endmodule : testbench
